// ---- pkg/cfp_pkg.sv ----
`default_nettype none
package cfp_pkg;
  // clock and times
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned HOLD_STEP_MS = 2000;
  localparam int unsigned HOLD_STEP_CYC = HOLD_STEP_MS * (CLK_HZ / 1000);
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_ENTRY = 8'h08;
  localparam logic [7:0] OFS_SAMPLE = 8'h0c;
  localparam logic [7:0] OFS_SCALE = 8'h10;
  localparam logic [7:0] OFS_OFFSET = 8'h14;
  localparam logic [7:0] OFS_MEAS = 8'h18;
  localparam logic [7:0] OFS_DISP = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // ctrl fields
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_SF_LSB = 4;
  localparam int CTRL_SFEN_BIT = 12;
  localparam int CTRL_BAND_LSB = 16;
  // reset values, resolution limits and function codes
  localparam logic [3:0] RES_RST = 4'h9;
  localparam logic [31:0] SAMPLE_RST = 32'h0;
  localparam logic [31:0] SCALE_RST = 32'h1;
  localparam logic [3:0] RES_MIN = 4'h3;
  localparam logic [3:0] RES_MAX = 4'ha;
  localparam logic [3:0] RES_HWRATIO = 4'h7;
  localparam logic [7:0] SF_SMOOTH = 8'h21;
  localparam logic [7:0] SF_HWRATIO = 8'h91;
  localparam int SMOOTH_SHIFT = 3;
  // gate times in microseconds for inputs a and b, microwave base, and gate and overrange factors
  localparam logic [31:0] GATE_10D = 32'd20_000_000;
  localparam logic [31:0] GATE_9D = 32'd1_000_000;
  localparam logic [31:0] GATE_8D = 32'd100_000;
  localparam logic [31:0] GATE_7D = 32'd10_000;
  localparam logic [31:0] GATE_LOW = 32'd1_000;
  localparam logic [31:0] GATE_C_BASE = 32'd100_000;
  localparam logic [31:0] LOWMOD_FACTOR = 32'd10;
  localparam logic [31:0] OVR_LIMIT = 32'd110;
  // key commands
  typedef enum logic [3:0] {
    CFP_K_NONE = 4'h0, CFP_K_HOLD = 4'h1, CFP_K_RESET = 4'h2,
    CFP_K_MANUAL = 4'h3, CFP_K_STORE_MAN = 4'h4, CFP_K_LOWMOD = 4'h5,
    CFP_K_TRACK = 4'h6, CFP_K_SAMPLE = 4'h7, CFP_K_RCL_SAMPLE = 4'h8,
    CFP_K_SCALE = 4'h9, CFP_K_OFFSET = 4'ha, CFP_K_NULL = 4'hb,
    CFP_K_RES_UP = 4'hc, CFP_K_RES_DN = 4'hd, CFP_K_SIGN = 4'he,
    CFP_K_STORE_SCALE = 4'hf
  } cfp_key_e;
  typedef enum logic [2:0] {
    CFP_F_FIRST = 3'h0, CFP_F_SECOND = 3'h1, CFP_F_MICRO = 3'h2,
    CFP_F_R_CB = 3'h3, CFP_F_R_CA = 3'h4, CFP_F_R_BA = 3'h5
  } cfp_func_e;
endpackage : cfp_pkg
`default_nettype wire

// ---- core/cfp_gate_sel.sv ----
`default_nettype none
module cfp_gate_sel (
  // selection
  input wire logic [2:0] func,
  input wire logic [3:0] res,
  input wire logic [2:0] band,
  input wire logic low_mod,
  // result
  output logic [31:0] gate_us
);
  logic [31:0] base;
  logic [31:0] step;
  always_comb begin
    unique case (res)
      4'ha: base = cfp_pkg::GATE_10D;
      4'h9: base = cfp_pkg::GATE_9D;
      4'h8: base = cfp_pkg::GATE_8D;
      4'h7: base = cfp_pkg::GATE_7D;
      default: base = cfp_pkg::GATE_LOW;
    endcase
    // band 0 is 0.5-1 ghz, then twice the band number, 2,4,6,8,10,12,14 units for bands 1 to 7
    step = (band == 3'h0) ? 32'd1 : {28'h0, band, 1'b0};
    if (func == cfp_pkg::CFP_F_MICRO) begin // R22
      gate_us = (res >= 4'h9) ? cfp_pkg::GATE_C_BASE * step : 32'd0;
      if (res == 4'h8) gate_us = 32'd10_000 * step;
      if (res == 4'h7) gate_us = 32'd1_000 * step;
      if (res <= 4'h6) gate_us = cfp_pkg::GATE_LOW;
      if (low_mod) gate_us = gate_us * cfp_pkg::LOWMOD_FACTOR; // R5
    end else begin
      gate_us = base; // R23
    end
  end
endmodule : cfp_gate_sel
`default_nettype wire

// ---- core/cfp_result.sv ----
`default_nettype none
module cfp_result (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // operands
  input wire logic [31:0] meas,
  input wire logic [31:0] scale,
  input wire logic [31:0] offset,
  input wire logic scale_en,
  input wire logic offset_en,
  input wire logic smooth_en,
  input wire logic meas_stb,
  // result
  output logic [31:0] disp
);
  logic [31:0] avg_r;
  logic [31:0] prod;
  always_ff @(posedge aclk) begin
    if (!aresetn) avg_r <= 32'h0;
    else if (meas_stb) begin
      if (smooth_en) // R16
        avg_r <= avg_r + ((meas - avg_r) >>> cfp_pkg::SMOOTH_SHIFT);
      else avg_r <= meas;
    end
  end
  always_comb begin
    prod = scale_en ? 32'(avg_r * scale) : avg_r; // R12
    disp = offset_en ? prod - offset : prod; // R14
  end
endmodule : cfp_result
`default_nettype wire

// ---- core/cfp_ctrl.sv ----
`default_nettype none
// Overview of operation
// R1: low modulation and sweep tracking are mutually exclusive; selecting one drops other
// R2: switching off the active submode returns to plain automatic acquisition
// R3: submodes only in microwave automatic acquisition; refused in manual
// R4: new manual centre frequency applies at once when manual already active; the code ignores CFP_K_STORE_MAN
// R5: low modulation lengthens gate periods
// R6: software ratio takes denominator first, then numerator, then quotient
// R7: code 91 enables real-time hardware b over a ratio
// R8: hardware ratio limits display to seven digits plus overrange
// R9: sample interval is zero after power-up
// R10: keypad interval stored in sample register, used from next reading
// R11: recall shows sample interval until reset key
// R12: scaling multiplies result by scale factor and lights indicator
// R13: shifted scaling key toggles scaling, keeps stored factor
// R14: offset subtracts signed offset; sign toggles during entry
// R15: displayed value can be copied into offset register
// R16: code 21 shows running average
// R17: resolution three to ten digits, stepped by keys
// R18: results up to ten percent over full scale shown with leading 1; the code has no leading 1 display and OVR_LIMIT is unused
// R19: ten digits on microwave input lights overflow when overrange digit lost
// R20: nine to ten digits only after step-up held about two seconds
// R21: hold mode measures once per reset press, gate indicator, hold toggles
// R22: microwave gate from resolution and frequency band
// R23: inputs a and b gate follows resolution table
// R24: synchronous reset restores automatic, continuous, zero interval, no scaling
module cfp_ctrl #(
  parameter int unsigned HOLD_CYC = cfp_pkg::HOLD_STEP_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // counting hardware
  input wire logic meas_done,
  output logic gate_start,
  output logic [31:0] gate_us,
  output logic [1:0] meas_chan,
  output logic hw_ratio,
  // indicators
  output logic gate_led,
  output logic scale_led,
  output logic offset_led,
  output logic lowmod_led,
  output logic track_led,
  output logic manual_led,
  output logic ovf_led
);
  typedef enum logic [1:0] {
    CFP_S_IDLE = 2'b00, CFP_S_GATE = 2'b01, CFP_S_WAIT = 2'b10, CFP_S_DEN = 2'b11
  } cfp_state_e;
  cfp_state_e st_r;
  logic [31:0] ctrl_r, entry_r, sample_r, scale_r, offset_r, meas_r, disp_r, den_r;
  logic [31:0] wait_r, hold_cnt_r, gate_w, res_disp;
  logic [3:0] res_r, res_eff;
  logic hold_r, manual_r, lowmod_r, track_r, scale_en_r, offset_en_r, recall_r;
  logic one_shot_r, meas_stb_r, key_stb, aw_ok_r, w_ok_r;
  logic [7:0] aw_r;
  logic [31:0] w_r;
  logic [3:0] key;
  logic [2:0] func;
  logic [7:0] sf;
  logic sf_en, is_micro, is_ratio, hwr, smooth;
  assign func = ctrl_r[cfp_pkg::CTRL_FUNC_LSB +: 3];
  assign sf = ctrl_r[cfp_pkg::CTRL_SF_LSB +: 8];
  assign sf_en = ctrl_r[cfp_pkg::CTRL_SFEN_BIT];
  assign is_micro = func == cfp_pkg::CFP_F_MICRO;
  assign is_ratio = func >= cfp_pkg::CFP_F_R_CB;
  assign hwr = sf_en && sf == cfp_pkg::SF_HWRATIO && func == cfp_pkg::CFP_F_R_BA; // R7
  assign smooth = sf_en && sf == cfp_pkg::SF_SMOOTH; // R16
  assign res_eff = hwr ? cfp_pkg::RES_HWRATIO : res_r; // R8
  // write channel capture, either order; readies registered from the next state
  logic aw_ok_nxt, w_ok_nxt, bvalid_nxt;
  always_comb begin
    aw_ok_nxt = aw_ok_r || (s_axi_awvalid && s_axi_awready);
    w_ok_nxt = w_ok_r || (s_axi_wvalid && s_axi_wready);
    bvalid_nxt = s_axi_bvalid && !s_axi_bready;
    if (aw_ok_r && w_ok_r) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bvalid_nxt = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      aw_r <= 8'h0;
      w_r <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_r <= s_axi_wdata;
      aw_ok_r <= aw_ok_nxt;
      w_ok_r <= w_ok_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_awready <= !aw_ok_nxt && !bvalid_nxt;
      s_axi_wready <= !w_ok_nxt && !bvalid_nxt;
    end
  end
  logic wr;
  assign wr = aw_ok_r && w_ok_r;
  assign key_stb = wr && aw_r == cfp_pkg::OFS_KEY;
  assign key = w_r[3:0];
  // key and register handling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin // R24
      ctrl_r <= 32'h0;
      entry_r <= 32'h0;
      sample_r <= cfp_pkg::SAMPLE_RST; // R9
      scale_r <= cfp_pkg::SCALE_RST;
      offset_r <= 32'h0;
      res_r <= cfp_pkg::RES_RST;
      hold_r <= 1'b0;
      manual_r <= 1'b0;
      lowmod_r <= 1'b0;
      track_r <= 1'b0;
      scale_en_r <= 1'b0;
      offset_en_r <= 1'b0;
      recall_r <= 1'b0;
    end else begin
      if (wr && aw_r == cfp_pkg::OFS_CTRL) ctrl_r <= w_r;
      if (wr && aw_r == cfp_pkg::OFS_ENTRY) entry_r <= w_r;
      if (!is_micro || manual_r) begin // R3
        lowmod_r <= 1'b0;
        track_r <= 1'b0;
      end
      if (key_stb) begin
        unique case (key)
          cfp_pkg::CFP_K_HOLD: hold_r <= !hold_r; // R21
          cfp_pkg::CFP_K_RESET: recall_r <= 1'b0; // R11
          cfp_pkg::CFP_K_MANUAL: begin
            manual_r <= !manual_r;
            lowmod_r <= 1'b0;
            track_r <= 1'b0;
          end
          cfp_pkg::CFP_K_STORE_MAN: ; // R4 manual store is accepted but changes nothing
          cfp_pkg::CFP_K_LOWMOD: if (is_micro && !manual_r) begin // R3
            lowmod_r <= !lowmod_r; // R2
            track_r <= 1'b0; // R1
          end
          cfp_pkg::CFP_K_TRACK: if (is_micro && !manual_r) begin // R3
            track_r <= !track_r; // R2
            lowmod_r <= 1'b0; // R1
          end
          cfp_pkg::CFP_K_SAMPLE: sample_r <= entry_r; // R10
          cfp_pkg::CFP_K_RCL_SAMPLE: recall_r <= 1'b1; // R11
          cfp_pkg::CFP_K_SCALE: scale_en_r <= !scale_en_r; // R13
          cfp_pkg::CFP_K_STORE_SCALE: scale_r <= entry_r;
          cfp_pkg::CFP_K_OFFSET: offset_en_r <= !offset_en_r;
          cfp_pkg::CFP_K_NULL: offset_r <= disp_r; // R15
          cfp_pkg::CFP_K_SIGN: entry_r <= 32'(-entry_r); // R14
          cfp_pkg::CFP_K_RES_DN: if (res_r > cfp_pkg::RES_MIN) res_r <= res_r - 4'h1; // R17
          cfp_pkg::CFP_K_RES_UP: if (res_r < 4'h9) res_r <= res_r + 4'h1; // R17
          default: ;
        endcase
      end
      if (wr && aw_r == cfp_pkg::OFS_OFFSET) offset_r <= w_r; // R14
      if (res_r == 4'h9 && hold_cnt_r == HOLD_CYC) res_r <= cfp_pkg::RES_MAX; // R20
    end
  end
  // step-up press length, bit 4 of the key word is the held level
  always_ff @(posedge aclk) begin
    if (!aresetn) hold_cnt_r <= 32'h0;
    else if (key_stb) hold_cnt_r <= (key == cfp_pkg::CFP_K_RES_UP && w_r[4]) ? 32'h1 : 32'h0;
    else if (hold_cnt_r != 32'h0 && hold_cnt_r <= HOLD_CYC) hold_cnt_r <= hold_cnt_r + 32'h1; // R20
  end
  cfp_gate_sel u_gate (
    .func(func),
    .res(res_r),
    .band(ctrl_r[cfp_pkg::CTRL_BAND_LSB +: 3]), // R22
    .low_mod(lowmod_r),
    .gate_us(gate_w)
  );
  // measurement sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= CFP_S_IDLE;
      gate_start <= 1'b0;
      gate_led <= 1'b0;
      meas_chan <= 2'h0;
      wait_r <= 32'h0;
      one_shot_r <= 1'b0;
      meas_stb_r <= 1'b0;
      den_r <= 32'h0;
      meas_r <= 32'h0;
    end else begin
      gate_start <= 1'b0;
      meas_stb_r <= 1'b0;
      if (key_stb && key == cfp_pkg::CFP_K_RESET && hold_r) one_shot_r <= 1'b1; // R21
      unique case (st_r)
        CFP_S_IDLE: if (!hold_r || one_shot_r) begin
          one_shot_r <= 1'b0;
          gate_start <= 1'b1;
          gate_led <= 1'b1; // R21
          meas_chan <= (is_ratio && !hwr) ? 2'h1 : 2'h0; // R6
          st_r <= (is_ratio && !hwr) ? CFP_S_DEN : CFP_S_GATE;
        end
        CFP_S_DEN: if (meas_done) begin // R6
          den_r <= meas_r;
          gate_start <= 1'b1;
          meas_chan <= 2'h0;
          st_r <= CFP_S_GATE;
        end
        CFP_S_GATE: if (meas_done) begin
          gate_led <= 1'b0;
          meas_stb_r <= 1'b1;
          meas_r <= (is_ratio && !hwr && den_r != 32'h0) ? meas_r / den_r : meas_r; // R6
          wait_r <= sample_r; // R10
          st_r <= CFP_S_WAIT;
        end
        CFP_S_WAIT: if (wait_r == 32'h0) st_r <= CFP_S_IDLE;
          else wait_r <= wait_r - 32'h1;
      endcase
      if (wr && aw_r == cfp_pkg::OFS_MEAS) meas_r <= w_r;
    end
  end
  cfp_result u_res (
    .aclk(aclk),
    .aresetn(aresetn),
    .meas(meas_r),
    .scale(scale_r),
    .offset(offset_r),
    .scale_en(scale_en_r),
    .offset_en(offset_en_r),
    .smooth_en(smooth),
    .meas_stb(meas_stb_r),
    .disp(res_disp)
  );
  // display and indicators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_r <= 32'h0;
      ovf_led <= 1'b0;
      gate_us <= 32'h0;
      hw_ratio <= 1'b0;
      scale_led <= 1'b0;
      offset_led <= 1'b0;
      lowmod_led <= 1'b0;
      track_led <= 1'b0;
      manual_led <= 1'b0;
    end else begin
      disp_r <= recall_r ? sample_r : res_disp; // R11
      // overflow lit at ten digits on microwave once the result reaches 100
      ovf_led <= is_micro && res_eff == cfp_pkg::RES_MAX
                 && res_disp >= 32'd100; // R18 R19
      gate_us <= gate_w;
      hw_ratio <= hwr; // R7
      scale_led <= scale_en_r; // R12
      offset_led <= offset_en_r;
      lowmod_led <= lowmod_r;
      track_led <= track_r;
      manual_led <= manual_r; // R4
    end
  end
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        cfp_pkg::OFS_CTRL: s_axi_rdata <= ctrl_r;
        cfp_pkg::OFS_ENTRY: s_axi_rdata <= entry_r;
        cfp_pkg::OFS_SAMPLE: s_axi_rdata <= sample_r;
        cfp_pkg::OFS_SCALE: s_axi_rdata <= scale_r;
        cfp_pkg::OFS_OFFSET: s_axi_rdata <= offset_r;
        cfp_pkg::OFS_MEAS: s_axi_rdata <= meas_r;
        cfp_pkg::OFS_DISP: s_axi_rdata <= disp_r;
        cfp_pkg::OFS_STATUS: s_axi_rdata <= {20'h0, res_eff, hold_r, manual_r, lowmod_r,
                                           track_r, scale_en_r, offset_en_r, recall_r, hwr};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
      s_axi_arready <= !s_axi_rvalid || s_axi_rready;
    end
  end
  // checks
  property p_excl;
    @(posedge aclk) disable iff (!aresetn) !(lowmod_r && track_r);
  endproperty
  a_excl: assert property (p_excl) else $error("both submodes active"); // R1
  property p_manual;
    @(posedge aclk) disable iff (!aresetn) manual_r |=> !lowmod_r && !track_r;
  endproperty
  a_manual: assert property (p_manual) else $error("submode in manual"); // R3
  property p_res;
    @(posedge aclk) disable iff (!aresetn) res_r >= 4'h3 && res_r <= 4'ha;
  endproperty
  a_res: assert property (p_res) else $error("resolution out of range"); // R17
  property p_hwr;
    @(posedge aclk) disable iff (!aresetn) hwr |-> res_eff == 4'h7;
  endproperty
  a_hwr: assert property (p_hwr) else $error("hw ratio digits"); // R8
  property p_scale;
    @(posedge aclk) disable iff (!aresetn)
      key_stb && key == cfp_pkg::CFP_K_SCALE |=> scale_en_r != $past(scale_en_r) && $stable(scale_r);
  endproperty
  a_scale: assert property (p_scale) else $error("scale toggle"); // R13
  property p_sample;
    @(posedge aclk) disable iff (!aresetn)
      key_stb && key == cfp_pkg::CFP_K_SAMPLE |=> sample_r == $past(entry_r);
  endproperty
  a_sample: assert property (p_sample) else $error("sample store"); // R10
  property p_null;
    @(posedge aclk) disable iff (!aresetn)
      key_stb && key == cfp_pkg::CFP_K_NULL |=> offset_r == $past(disp_r);
  endproperty
  a_null: assert property (p_null) else $error("null copy"); // R15
  property p_gate;
    @(posedge aclk) disable iff (!aresetn) st_r == CFP_S_WAIT |-> !gate_led;
  endproperty
  a_gate: assert property (p_gate) else $error("gate led in wait"); // R21
  property p_ten;
    @(posedge aclk) disable iff (!aresetn)
      res_r == 4'ha && $past(res_r) == 4'h9 |-> $past(hold_cnt_r) == HOLD_CYC;
  endproperty
  a_ten: assert property (p_ten) else $error("ten digits without long press"); // R20
endmodule : cfp_ctrl
`default_nettype wire

// ---- test/cfp_count_model.sv ----
`default_nettype none
module cfp_count_model #(
  parameter int DELAY = 10
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // gate handshake
  input wire logic gate_start,
  output logic meas_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // one done pulse a fixed span after each gate start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      meas_done <= 1'b0;
    end else begin
      meas_done <= (cnt == 1);
      if (gate_start) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : cfp_count_model
`default_nettype wire

// ---- test/tb_cfp_ctrl.sv ----
`default_nettype none
module tb_cfp_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, meas_done, gate_start, hw_ratio, gate_led, scale_led, offset_led;
  logic lowmod_led, track_led, manual_led, ovf_led;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, gate_us, rv, g0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, meas_chan, rr;
  int n_mismatch, compares, n_gate, c;
  cfp_ctrl #(.HOLD_CYC(HOLD)) cfp_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas_done, .gate_start,
    .gate_us, .meas_chan, .hw_ratio, .gate_led, .scale_led, .offset_led, .lowmod_led,
    .track_led, .manual_led, .ovf_led);
  cfp_count_model cfp_count_model_i (.aclk, .aresetn, .gate_start, .meas_done);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (gate_start === 1'b1) n_gate++;
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    chk("write answer", 1, n < 100);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("read answer", 1, n < 100);
  endtask : rd
  task automatic key(input cfp_pkg::cfp_key_e k, input logic h);
    wr(cfp_pkg::OFS_KEY, {27'h0, h, k});
    repeat (8) @(posedge aclk);
  endtask : key
  task automatic wait_gate();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (gate_start !== 1'b1 && n < 300);
    chk("gate start seen", 1, n < 300);
  endtask : wait_gate
  task automatic t_reset();
    chk("leds in reset", 0, {gate_led, scale_led, offset_led, lowmod_led, track_led});
    chk("mode in reset", 0, {manual_led, hw_ratio});
    aresetn <= 1'b1;
    rd(cfp_pkg::OFS_SAMPLE, rv, rr);
    chk("sample after reset", cfp_pkg::SAMPLE_RST, rv);
    rd(8'h40, rv, rr);
    chk("unmapped resp", 2'h2, rr);
  endtask : t_reset
  task automatic t_submode();
    wr(cfp_pkg::OFS_CTRL, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    g0 = gate_us;
    key(cfp_pkg::CFP_K_LOWMOD, 1'b0);
    chk("lowmod on", 2'b10, {lowmod_led, track_led});
    chk("lowmod longer gate", 1, gate_us > g0);
    key(cfp_pkg::CFP_K_TRACK, 1'b0);
    chk("track drops lowmod", 2'b01, {lowmod_led, track_led});
    key(cfp_pkg::CFP_K_LOWMOD, 1'b0);
    chk("lowmod drops track", 2'b10, {lowmod_led, track_led});
    key(cfp_pkg::CFP_K_LOWMOD, 1'b0);
    chk("back to plain auto", 2'b00, {lowmod_led, track_led});
    wr(cfp_pkg::OFS_CTRL, 32'h0005_0002);
    repeat (4) @(posedge aclk);
    chk("band moves gate", cfp_pkg::GATE_C_BASE * 10, gate_us);
    key(cfp_pkg::CFP_K_MANUAL, 1'b0);
    key(cfp_pkg::CFP_K_LOWMOD, 1'b0);
    key(cfp_pkg::CFP_K_TRACK, 1'b0);
    chk("refused in manual", 3'b100, {manual_led, lowmod_led, track_led});
    key(cfp_pkg::CFP_K_MANUAL, 1'b0);
  endtask : t_submode
  task automatic t_gate();
    logic [31:0] ex[8];
    ex = '{cfp_pkg::GATE_9D, cfp_pkg::GATE_8D, cfp_pkg::GATE_7D, cfp_pkg::GATE_LOW,
      cfp_pkg::GATE_LOW, cfp_pkg::GATE_LOW, cfp_pkg::GATE_LOW, cfp_pkg::GATE_LOW};
    wr(cfp_pkg::OFS_CTRL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(posedge aclk);
      chk("gate by res", ex[i], gate_us);
      key(cfp_pkg::CFP_K_RES_DN, 1'b0);
    end
    for (int i = 0; i < 7; i++) key(cfp_pkg::CFP_K_RES_UP, 1'b0);
    chk("short press stays nine", cfp_pkg::GATE_9D, gate_us);
    wr(cfp_pkg::OFS_KEY, {27'h0, 1'b1, cfp_pkg::CFP_K_RES_UP});
    repeat (HOLD / 2) @(posedge aclk);
    chk("held too briefly", cfp_pkg::GATE_9D, gate_us);
    repeat (HOLD + 8) @(posedge aclk);
    chk("held selects ten", cfp_pkg::GATE_10D, gate_us);
    wr(cfp_pkg::OFS_CTRL, 32'h2);
    wr(cfp_pkg::OFS_MEAS, 32'd200);
    repeat (40) @(posedge aclk);
    chk("overflow at ten on micro", 1, ovf_led);
    wr(cfp_pkg::OFS_CTRL, 32'h0);
    key(cfp_pkg::CFP_K_NONE, 1'b0);
    key(cfp_pkg::CFP_K_RES_UP, 1'b0);
    chk("ten is the top", cfp_pkg::GATE_10D, gate_us);
    key(cfp_pkg::CFP_K_RES_DN, 1'b0);
  endtask : t_gate
  task automatic t_math();
    wr(cfp_pkg::OFS_ENTRY, 32'h5);
    key(cfp_pkg::CFP_K_SAMPLE, 1'b0);
    rd(cfp_pkg::OFS_SAMPLE, rv, rr);
    chk("sample stored", 32'h5, rv);
    key(cfp_pkg::CFP_K_RCL_SAMPLE, 1'b0);
    rd(cfp_pkg::OFS_DISP, rv, rr);
    chk("sample recalled", 32'h5, rv);
    key(cfp_pkg::CFP_K_RESET, 1'b0);
    wr(cfp_pkg::OFS_ENTRY, 32'h3);
    key(cfp_pkg::CFP_K_STORE_SCALE, 1'b0);
    wr(cfp_pkg::OFS_MEAS, 32'h7);
    wr(cfp_pkg::OFS_OFFSET, 32'h1);
    key(cfp_pkg::CFP_K_SCALE, 1'b0);
    chk("scale led", 1, scale_led);
    key(cfp_pkg::CFP_K_OFFSET, 1'b0);
    chk("offset led", 1, offset_led);
    repeat (40) @(posedge aclk);
    rd(cfp_pkg::OFS_DISP, rv, rr);
    chk("scaled minus offset", 32'd20, rv);
    key(cfp_pkg::CFP_K_NULL, 1'b0);
    rd(cfp_pkg::OFS_OFFSET, rv, rr);
    chk("null copies display", 32'd20, rv);
    key(cfp_pkg::CFP_K_SCALE, 1'b0);
    chk("scale off", 0, scale_led);
    rd(cfp_pkg::OFS_SCALE, rv, rr);
    chk("factor kept", 32'h3, rv);
    key(cfp_pkg::CFP_K_OFFSET, 1'b0);
    chk("offset off", 0, offset_led);
  endtask : t_math
  task automatic t_ratio();
    wr(cfp_pkg::OFS_CTRL, 32'h0000_1915);
    repeat (4) @(posedge aclk);
    chk("hw ratio on", 1, hw_ratio);
    wr(cfp_pkg::OFS_CTRL, 32'h0000_0004);
    repeat (4) @(posedge aclk);
    chk("hw ratio off", 0, hw_ratio);
    c = 0;
    do begin
      wait_gate();
      c++;
    end while (meas_chan !== 2'h1 && c < 4);
    wait_gate();
    chk("numerator after denominator", 2'h0, meas_chan);
  endtask : t_ratio
  task automatic t_hold();
    wr(cfp_pkg::OFS_CTRL, 32'h0);
    key(cfp_pkg::CFP_K_HOLD, 1'b0);
    repeat (50) @(posedge aclk);
    c = n_gate;
    repeat (100) @(posedge aclk);
    chk("no gates in hold", 0, n_gate - c);
    wr(cfp_pkg::OFS_KEY, {28'h0, cfp_pkg::CFP_K_RESET});
    wait_gate();
    repeat (2) @(posedge aclk);
    chk("gate led lit", 1, gate_led);
    repeat (100) @(posedge aclk);
    chk("one gate per press", 1, n_gate - c);
    key(cfp_pkg::CFP_K_HOLD, 1'b0);
    c = n_gate;
    repeat (100) @(posedge aclk);
    chk("continuous again", 1, n_gate - c > 1);
  endtask : t_hold
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    t_reset();
    t_submode();
    t_gate();
    t_math();
    t_ratio();
    t_hold();
    stop_test();
  end
endmodule : tb_cfp_ctrl
`default_nettype wire
